// ===== logic/pmes_pkg.sv
// Shared constants for the nonvolatile memory program/erase sequencer.
// Assumes APB with 32-bit data and 12-bit byte addresses.
`default_nettype none
package pmes_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_CTRL     = 12'h18c;
   localparam logic [11:0] OFF_UNLOCK   = 12'h190;
   localparam logic [11:0] OFF_ADDR_LO  = 12'h194;
   localparam logic [11:0] OFF_ADDR_HI  = 12'h198;
   localparam logic [11:0] OFF_DATA_LO  = 12'h19c;
   localparam logic [11:0] OFF_DATA_HI  = 12'h1a0;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h1a4;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h1a8;

   // Control register fields
   localparam int BIT_SPACE = 7;
   localparam int BIT_FREE  = 4;
   localparam int BIT_WERR  = 3;
   localparam int BIT_WRITE_PERMIT_BIT  = 2;
   localparam int BIT_WR    = 1;
   localparam int BIT_RD    = 0;

   // Interrupt status fields
   localparam int IRQ_WDONE = 0;
   localparam int IRQ_WERR  = 1;
   localparam int IRQ_RDONE = 2;
   localparam int IRQ_W     = 3;

   // Reset values
   localparam logic [7:0]       CTRL_RST = 8'h00;
   localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

   // Unlock keys
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // Memory geometry
   localparam int FLASH_AW    = 13;
   localparam int WORD_W      = 14;
   localparam int DATA_HI_W   = WORD_W - 8;
   localparam int GROUP_WORDS = 4;
   localparam int GROUP_LSB   = 2;
   localparam int ROW_LSB     = 5;

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} pmes_op_t;
endpackage
`default_nettype wire

// ===== logic/pmes_sequencer.sv
// Program flash / data EEPROM program-erase sequencer with APB registers.
// Assumes a memory macro that takes a held request and returns a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
module pmes_sequencer
   import pmes_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   // Abort sources
   input  wire logic                 ext_reset_pin_evt,
   input  wire logic                 watchdog_reset_evt,
   // Memory macro
   output logic                      mem_req,
   output pmes_op_t                  mem_op,
   output logic                      mem_space,
   output logic [FLASH_AW-1:0]       mem_addr,
   output logic [GROUP_WORDS*WORD_W-1:0] mem_wdata,
   input  wire logic                 mem_ack,
   input  wire logic [WORD_W-1:0]    mem_rdata,
   // Core side
   output logic                      fetch_hold,
   output logic                      irq
);
   typedef enum logic [1:0] {ST_IDLE, ST_LATCH, ST_MEM} pmes_st_t;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == OFF_CTRL) || (a == OFF_UNLOCK) || (a == OFF_ADDR_LO) || (a == OFF_ADDR_HI)
                  || (a == OFF_DATA_LO) || (a == OFF_DATA_HI) || (a == OFF_IRQ_STAT)
                  || (a == OFF_IRQ_MASK);
   endfunction

   // Sequencer state
   pmes_st_t                      st_r,      st_nxt;
   pmes_op_t                      op_r,      op_nxt;
   logic                          space_r,   space_nxt;
   logic                          free_r,    free_nxt;
   logic                          werr_r,    werr_nxt;
   logic                          write_permit_bit_r,    write_permit_bit_nxt;
   logic                          wr_r,      wr_nxt;
   logic                          rd_r,      rd_nxt;
   logic                          req_r,     req_nxt;
   logic [FLASH_AW-1:0]           maddr_r,   maddr_nxt;
   logic [GROUP_WORDS*WORD_W-1:0] mwdata_r,  mwdata_nxt;
   logic [7:0]                    addr_lo_r, addr_lo_nxt;
   logic [7:0]                    addr_hi_r, addr_hi_nxt;
   logic [7:0]                    data_lo_r, data_lo_nxt;
   logic [DATA_HI_W-1:0]          data_hi_r, data_hi_nxt;
   logic [WORD_W-1:0]             grp_buf_r   [0:GROUP_WORDS-2];
   logic [WORD_W-1:0]             grp_buf_nxt [0:GROUP_WORDS-2];
   logic [IRQ_W-1:0]              stat_r,    stat_nxt;
   logic [IRQ_W-1:0]              mask_r,    mask_nxt;
   logic [31:0]                   rdata_r,   rdata_nxt;

   logic                          acc;
   logic                          fire;
   logic                          start_req;
   logic                          busy;
   logic                          ctrl_wr;
   logic                          armed;
   logic                          abort_evt;
   logic                          ev_wdone;
   logic                          ev_werr;
   logic                          ev_rdone;
   logic [FLASH_AW-1:0]           cur_addr;
   logic [WORD_W-1:0]             cur_word;

   assign acc       = psel & penable;
   assign busy      = (st_r != ST_IDLE);
   assign start_req = acc & pwrite & (paddr == OFF_CTRL) & (pwdata[BIT_WR] | pwdata[BIT_RD]);
   assign pready    = ~(start_req & busy);
   assign pslverr   = acc & ~is_mapped(paddr);
   assign fire      = acc & pready & pwrite & is_mapped(paddr);
   assign ctrl_wr   = fire & (paddr == OFF_CTRL);
   assign abort_evt = ext_reset_pin_evt | watchdog_reset_evt;
   assign cur_addr  = {addr_hi_r[FLASH_AW-9:0], addr_lo_r};
   assign cur_word  = {data_hi_r, data_lo_r};

   // Any other register write between the keys breaks the sequence, except a control register write that leaves the write start bit clear
   pmes_unlock u_unlock (
      .clock     (clock),
      .rst       (rst),
      .key_wr    (fire & (paddr == OFF_UNLOCK)),
      .key_data  (pwdata[7:0]),
      .break_seq (fire & (paddr != OFF_UNLOCK) & (paddr != OFF_CTRL)),
      .consume   (ctrl_wr & pwdata[BIT_WR]),
      .armed     (armed)
   );

   always_comb
   begin
      st_nxt      = st_r;
      op_nxt      = op_r;
      space_nxt   = space_r;
      free_nxt    = free_r;
      werr_nxt    = werr_r;
      write_permit_bit_nxt    = write_permit_bit_r;
      wr_nxt      = wr_r;
      rd_nxt      = rd_r;
      req_nxt     = req_r;
      maddr_nxt   = maddr_r;
      mwdata_nxt  = mwdata_r;
      addr_lo_nxt = addr_lo_r;
      addr_hi_nxt = addr_hi_r;
      data_lo_nxt = data_lo_r;
      data_hi_nxt = data_hi_r;
      grp_buf_nxt = grp_buf_r;
      ev_wdone    = 1'b0;
      ev_werr     = 1'b0;
      ev_rdone    = 1'b0;

      if (fire && paddr == OFF_ADDR_LO)
         addr_lo_nxt = pwdata[7:0];
      if (fire && paddr == OFF_ADDR_HI)
         addr_hi_nxt = pwdata[7:0];
      if (fire && paddr == OFF_DATA_LO)
         data_lo_nxt = pwdata[7:0];
      if (fire && paddr == OFF_DATA_HI)
         data_hi_nxt = pwdata[DATA_HI_W-1:0];

      if (ctrl_wr)
      begin
         free_nxt = pwdata[BIT_FREE];
         werr_nxt = pwdata[BIT_WERR];
         write_permit_bit_nxt = pwdata[BIT_WRITE_PERMIT_BIT];
         // Space may not move under a write in flight
         if (!busy)
            space_nxt = pwdata[BIT_SPACE];
      end

      if (abort_evt)
      begin
         if (busy && op_r != OP_READ)
         begin
            werr_nxt = 1'b1;
            ev_werr  = 1'b1;
         end
         st_nxt   = ST_IDLE;
         wr_nxt   = 1'b0;
         rd_nxt   = 1'b0;
         write_permit_bit_nxt = 1'b0;
         req_nxt  = 1'b0;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE:
            begin
               // Zero in the start bits is ignored
               if (ctrl_wr && pwdata[BIT_RD])
               begin
                  rd_nxt  = 1'b1;
                  op_nxt  = OP_READ;
                  st_nxt  = ST_MEM;
                  req_nxt = 1'b1;
                  // Data EEPROM sees only the low address byte
                  maddr_nxt = pwdata[BIT_SPACE] ? cur_addr : {5'h00, addr_lo_r};
               end
               else if (ctrl_wr && pwdata[BIT_WR] && write_permit_bit_r && armed)
               begin
                  wr_nxt = 1'b1;
                  if (pwdata[BIT_SPACE] && pwdata[BIT_FREE])
                  begin
                     op_nxt    = OP_ERASE;
                     st_nxt    = ST_MEM;
                     req_nxt   = 1'b1;
                     maddr_nxt = {cur_addr[FLASH_AW-1:ROW_LSB], 5'h00};
                  end
                  else if (pwdata[BIT_SPACE])
                  begin
                     op_nxt = OP_WRITE;
                     // Words collect until the last slot of the group
                     if (cur_addr[GROUP_LSB-1:0] == 2'h3)
                     begin
                        st_nxt     = ST_MEM;
                        req_nxt    = 1'b1;
                        maddr_nxt  = {cur_addr[FLASH_AW-1:GROUP_LSB], 2'h0};
                        mwdata_nxt = {cur_word, grp_buf_r[2], grp_buf_r[1], grp_buf_r[0]};
                     end
                     else
                     begin
                        st_nxt = ST_LATCH;
                        grp_buf_nxt[cur_addr[GROUP_LSB-1:0]] = cur_word;
                     end
                  end
                  else
                  begin
                     op_nxt     = OP_WRITE;
                     st_nxt     = ST_MEM;
                     req_nxt    = 1'b1;
                     maddr_nxt  = {5'h00, addr_lo_r};
                     mwdata_nxt = {{(GROUP_WORDS*WORD_W-8){1'b0}}, data_lo_r};
                  end
               end
            end
            ST_LATCH:
            begin
               wr_nxt   = 1'b0;
               st_nxt   = ST_IDLE;
               ev_wdone = 1'b1;
            end
            ST_MEM:
            begin
               if (mem_ack)
               begin
                  req_nxt = 1'b0;
                  st_nxt  = ST_IDLE;
                  if (op_r == OP_READ)
                  begin
                     rd_nxt      = 1'b0;
                     ev_rdone    = 1'b1;
                     data_lo_nxt = mem_rdata[7:0];
                     if (space_r)
                        data_hi_nxt = mem_rdata[WORD_W-1:8];
                  end
                  else
                  begin
                     wr_nxt   = 1'b0;
                     ev_wdone = 1'b1;
                  end
               end
            end
            default:
               st_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         st_r      <= ST_IDLE;
         op_r      <= OP_READ;
         space_r   <= CTRL_RST[BIT_SPACE];
         free_r    <= CTRL_RST[BIT_FREE];
         werr_r    <= CTRL_RST[BIT_WERR];
         write_permit_bit_r    <= CTRL_RST[BIT_WRITE_PERMIT_BIT];
         wr_r      <= CTRL_RST[BIT_WR];
         rd_r      <= CTRL_RST[BIT_RD];
         req_r     <= 1'b0;
         maddr_r   <= '0;
         mwdata_r  <= '0;
         addr_lo_r <= 8'h00;
         addr_hi_r <= 8'h00;
         data_lo_r <= 8'h00;
         data_hi_r <= '0;
         for (int i = 0; i < GROUP_WORDS - 1; i++)
            grp_buf_r[i] <= '0;
      end
      else
      begin
         st_r      <= st_nxt;
         op_r      <= op_nxt;
         space_r   <= space_nxt;
         free_r    <= free_nxt;
         werr_r    <= werr_nxt;
         write_permit_bit_r    <= write_permit_bit_nxt;
         wr_r      <= wr_nxt;
         rd_r      <= rd_nxt;
         req_r     <= req_nxt;
         maddr_r   <= maddr_nxt;
         mwdata_r  <= mwdata_nxt;
         addr_lo_r <= addr_lo_nxt;
         addr_hi_r <= addr_hi_nxt;
         data_lo_r <= data_lo_nxt;
         data_hi_r <= data_hi_nxt;
         grp_buf_r <= grp_buf_nxt;
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   always_comb
   begin
      stat_nxt = stat_r;
      mask_nxt = mask_r;
      if (fire && paddr == OFF_IRQ_STAT)
         stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
      if (fire && paddr == OFF_IRQ_MASK)
         mask_nxt = pwdata[IRQ_W-1:0];
      stat_nxt[IRQ_WDONE] = stat_nxt[IRQ_WDONE] | ev_wdone;
      stat_nxt[IRQ_WERR]  = stat_nxt[IRQ_WERR] | ev_werr;
      stat_nxt[IRQ_RDONE] = stat_nxt[IRQ_RDONE] | ev_rdone;
   end

   // Read data captured every selected cycle, valid in the access phase
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      unique case (paddr)
         OFF_CTRL:     rdata_nxt[7:0] = {space_r, 2'b00, free_r, werr_r, write_permit_bit_r, wr_r, rd_r};
         OFF_ADDR_LO:  rdata_nxt[7:0] = addr_lo_r;
         OFF_ADDR_HI:  rdata_nxt[7:0] = addr_hi_r;
         OFF_DATA_LO:  rdata_nxt[7:0] = data_lo_r;
         OFF_DATA_HI:  rdata_nxt[DATA_HI_W-1:0] = data_hi_r;
         OFF_IRQ_STAT: rdata_nxt[IRQ_W-1:0] = stat_r;
         OFF_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = mask_r;
         default:      rdata_nxt = 32'h0000_0000;
      endcase
      if (!psel)
         rdata_nxt = rdata_r;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         stat_r  <= '0;
         mask_r  <= MASK_RST;
         rdata_r <= 32'h0000_0000;
      end
      else
      begin
         stat_r  <= stat_nxt;
         mask_r  <= mask_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign prdata     = rdata_r;
   assign irq        = |(stat_r & mask_r);
   assign mem_req    = req_r;
   assign mem_op     = op_r;
   assign mem_space  = space_r;
   assign mem_addr   = maddr_r;
   assign mem_wdata  = mwdata_r;
   // Core stalls fetch rather than trusting software to pad with no-ops
   assign fetch_hold = busy & space_r & (op_r != OP_READ);
endmodule
`default_nettype wire

// ===== logic/pmes_unlock.sv
// Unlock key detector: arms after the two keys arrive back to back.
// Assumes single-cycle write strobes from the bus slave.
`timescale 1ns/10ps
`default_nettype none
module pmes_unlock
   import pmes_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Key writes
   input  wire logic       key_wr,
   input  wire logic [7:0] key_data,
   input  wire logic       break_seq,
   input  wire logic       consume,
   // State
   output logic            armed
);
   typedef enum logic [1:0] {UL_IDLE, UL_HALF, UL_ARMED} pmes_ul_t;

   pmes_ul_t st_r;
   pmes_ul_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      if (consume || break_seq)
      begin
         st_nxt = UL_IDLE;
      end
      else if (key_wr)
      begin
         unique case (st_r)
            UL_IDLE:  st_nxt = (key_data == KEY_FIRST) ? UL_HALF : UL_IDLE;
            UL_HALF:  st_nxt = (key_data == KEY_SECOND) ? UL_ARMED
                               : ((key_data == KEY_FIRST) ? UL_HALF : UL_IDLE);
            UL_ARMED: st_nxt = (key_data == KEY_FIRST) ? UL_HALF : UL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         st_r <= UL_IDLE;
      else
         st_r <= st_nxt;
   end

   assign armed = (st_r == UL_ARMED);
endmodule
`default_nettype wire

// ===== testbench/pmes_props.sv
// Checker for the program/erase sequencer.
// Sees only the top ports; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module pmes_props
   import pmes_pkg::*;
(
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // Aborts and memory
   input wire logic        ext_reset_pin_evt,
   input wire logic        watchdog_reset_evt,
   input wire logic        mem_req,
   input wire pmes_op_t    mem_op,
   input wire logic        mem_space,
   input wire logic [12:0] mem_addr,
   input wire logic [55:0] mem_wdata,
   input wire logic        mem_ack,
   input wire logic [13:0] mem_rdata,
   // Core side
   input wire logic        fetch_hold,
   input wire logic        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic acc;
   logic start;
   assign acc = psel && penable;
   assign start = acc && pwrite && paddr == OFF_CTRL && pwdata[1:0] != 2'b00;
   // Abort pulses may cut a request short
   sequence s_wait;
      mem_req && !mem_ack && !ext_reset_pin_evt && !watchdog_reset_evt;
   endsequence
   sequence s_abort;
      mem_req && (ext_reset_pin_evt || watchdog_reset_evt);
   endsequence
   a_req_holds: assert property (s_wait |=> mem_req && $stable(mem_op) && $stable(mem_addr) && $stable(mem_wdata))
      else $error("request changed before ack");
   a_req_ends: assert property (mem_req && mem_ack |=> !mem_req) else $error("request outlived ack");
   a_req_cause: assert property ($rose(mem_req) |-> $past(start && pready))
      else $error("request without start bit");
   a_abort_drop: assert property (s_abort |=> !mem_req) else $error("abort left request up");
   a_busy_stall: assert property (start && mem_req |-> !pready) else $error("start taken while busy");
   a_erase_row: assert property (mem_req && mem_op == OP_ERASE |-> mem_space && mem_addr[4:0] == 5'h00)
      else $error("erase not row aligned");
   a_group_align: assert property (mem_req && mem_space && mem_op == OP_WRITE |-> mem_addr[1:0] == 2'b00)
      else $error("group write misaligned");
   a_eeprom_range: assert property (mem_req && !mem_space |-> mem_addr[12:8] == 5'h00)
      else $error("eeprom address out of range");
   a_fetch_hold: assert property (mem_req && mem_space && mem_op != OP_READ |-> fetch_hold)
      else $error("fetch not held in flash write");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !mem_req && !irq && prdata == 32'h0)
      else $error("outputs not cleared by reset");
endmodule
bind pmes_sequencer pmes_props u_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .ext_reset_pin_evt(ext_reset_pin_evt), .watchdog_reset_evt(watchdog_reset_evt), .mem_req(mem_req),
   .mem_op(mem_op), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
   .mem_rdata(mem_rdata), .fetch_hold(fetch_hold), .irq(irq));
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the program/erase sequencer.
// Bench is APB master and memory macro stand-in.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import pmes_pkg::*;
;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, seed;
   logic        ext_evt, wd_evt, mem_req, mem_space, mem_ack, fetch_hold, irq;
   pmes_op_t    mem_op;
   logic [12:0] mem_addr;
   logic [55:0] mem_wdata, wd_exp;
   logic [13:0] mem_rdata, r14, w14, last_rd;
   logic [71:0] q_req[$];
   logic [7:0]  lo, d8;
   logic [4:0]  hi;
   int          errors, comparisons, waits, ack_delay, wait_cnt;

   pmes_sequencer dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .ext_reset_pin_evt(ext_evt), .watchdog_reset_evt(wd_evt), .mem_req(mem_req), .mem_op(mem_op),
      .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .fetch_hold(fetch_hold), .irq(irq));

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Memory stand-in; slow answers keep the sequencer busy
   always @(posedge clock)
   begin
      if (rst)
      begin
         mem_ack <= 1'b0;
         mem_rdata <= 14'h0000;
         wait_cnt <= 0;
      end
      else
      begin
         mem_ack <= 1'b0;
         wait_cnt <= mem_req ? wait_cnt + 1 : 0;
         if (mem_req && !mem_ack && wait_cnt >= ack_delay)
         begin
            r14 = 14'($urandom);
            last_rd = r14;
            mem_ack <= 1'b1;
            mem_rdata <= r14;
            wait_cnt <= 0;
            q_req.push_back({mem_op, mem_space, mem_addr, mem_wdata});
         end
      end
   end

   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 300);
      if (pready !== 1'b1)
      begin
         errors++;
         end_of_test();
      end
      else
      begin
         waits = n - 1;
         rdata = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic keys();
      wr(OFF_UNLOCK, {24'h0, KEY_FIRST});
      wr(OFF_UNLOCK, {24'h0, KEY_SECOND});
   endtask

   // Polls until both start bits read back clear
   task automatic wait_idle();
      int n;
      n = 0;
      do
      begin
         rd(OFF_CTRL);
         n++;
      end
      while (rdata[1:0] !== 2'b00 && n < 100);
      check(rdata[1:0], 2'b00);
      if (rdata[1:0] !== 2'b00)
         end_of_test();
   endtask

   task automatic expect_req(input pmes_op_t op, input logic sp, input logic [12:0] ad,
                             input logic [55:0] wd, input logic [55:0] m);
      logic [71:0] got;
      got = (q_req.size() > 0) ? q_req.pop_front() : 'x;
      check(got & {16'hffff, m}, {op, sp, ad, wd & m});
   endtask

   initial
   begin
      {rst, psel, penable, pwrite, ext_evt, wd_evt} = 6'h20;
      paddr = 12'h000;
      pwdata = 32'h0;
      errors = 0;
      comparisons = 0;
      ack_delay = 1;
      seed = $urandom(32'h8952);
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(OFF_CTRL);
      check(rdata, {24'h0, CTRL_RST});
      rd(OFF_IRQ_MASK);
      check(rdata, {29'h0, MASK_RST});
      rd(12'h1fc);
      check({err, rdata}, {1'b1, 32'h0});
      // Refused starts: no permit, broken key pair, reversed keys
      keys();
      wr(OFF_CTRL, 32'h02);
      rd(OFF_CTRL);
      check(rdata, 32'h00);
      wr(OFF_CTRL, 32'h04);
      wr(OFF_UNLOCK, {24'h0, KEY_FIRST});
      wr(OFF_ADDR_LO, 32'h11);
      wr(OFF_UNLOCK, {24'h0, KEY_SECOND});
      wr(OFF_CTRL, 32'h06);
      wr(OFF_UNLOCK, {24'h0, KEY_SECOND});
      wr(OFF_UNLOCK, {24'h0, KEY_FIRST});
      wr(OFF_CTRL, 32'h06);
      rd(OFF_CTRL);
      check({q_req.size(), rdata}, 32'h04);
      // EEPROM write, set-only start bit, held-off read
      lo = 8'($urandom);
      d8 = 8'($urandom);
      wr(OFF_IRQ_MASK, 32'h7);
      wr(OFF_ADDR_LO, {24'h0, lo});
      wr(OFF_DATA_LO, {24'h0, d8});
      ack_delay = 12;
      keys();
      wr(OFF_CTRL, 32'h06);
      wr(OFF_CTRL, 32'h04);
      rd(OFF_CTRL);
      check(rdata, 32'h06);
      wr(OFF_CTRL, 32'h05);
      check(waits > 0, 1'b1);
      wait_idle();
      expect_req(OP_WRITE, 1'b0, {5'h0, lo}, {48'h0, d8}, 56'hff);
      expect_req(OP_READ, 1'b0, {5'h0, lo}, 56'h0, 56'h0);
      rd(OFF_DATA_LO);
      check(rdata[7:0], last_rd[7:0]);
      rd(OFF_IRQ_STAT);
      check({irq, rdata}, {1'b1, 32'h5});
      wr(OFF_IRQ_MASK, 32'h2);
      rd(OFF_IRQ_STAT);
      check(irq, 1'b0);
      wr(OFF_IRQ_STAT, 32'h5);
      wr(OFF_IRQ_MASK, 32'h7);
      rd(OFF_IRQ_STAT);
      check({irq, rdata}, 33'h0);
      // Flash row erase, four-word group, flash read
      ack_delay = 3;
      hi = 5'($urandom);
      lo = 8'($urandom);
      wr(OFF_ADDR_HI, {27'h0, hi});
      wr(OFF_ADDR_LO, {24'h0, lo});
      wr(OFF_CTRL, 32'h94);
      keys();
      wr(OFF_CTRL, 32'h96);
      wait_idle();
      expect_req(OP_ERASE, 1'b1, {hi, lo[7:5], 5'h0}, 56'h0, 56'h0);
      wr(OFF_CTRL, 32'h84);
      for (int i = 0; i < GROUP_WORDS; i++)
      begin
         w14 = 14'($urandom);
         wd_exp[i*WORD_W +: WORD_W] = w14;
         wr(OFF_ADDR_LO, {24'h0, lo[7:2], 2'(i)});
         wr(OFF_DATA_LO, {24'h0, w14[7:0]});
         wr(OFF_DATA_HI, {26'h0, w14[13:8]});
         keys();
         wr(OFF_CTRL, 32'h86);
         wait_idle();
      end
      check(q_req.size(), 1);
      expect_req(OP_WRITE, 1'b1, {hi, lo[7:2], 2'b00}, wd_exp, '1);
      wr(OFF_CTRL, 32'h81);
      wait_idle();
      expect_req(OP_READ, 1'b1, {hi, lo[7:2], 2'b11}, 56'h0, 56'h0);
      rd(OFF_DATA_HI);
      check(rdata[5:0], last_rd[13:8]);
      // Write cut short by each abort source
      for (int i = 0; i < 2; i++)
      begin
         ack_delay = 40;
         wr(OFF_CTRL, 32'h04);
         keys();
         wr(OFF_CTRL, 32'h06);
         @(posedge clock);
         ext_evt <= (i == 0);
         wd_evt <= (i == 1);
         @(posedge clock);
         ext_evt <= 1'b0;
         wd_evt <= 1'b0;
         rd(OFF_CTRL);
         check(rdata, 32'h08);
         rd(OFF_IRQ_STAT);
         check({q_req.size(), rdata[1]}, 1'b1);
         wr(OFF_IRQ_STAT, 32'h7);
         wr(OFF_CTRL, 32'h00);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
